// [pkg/dct_pkg.sv]
package dct_pkg;

  // ------------------------------------------------------------
  // Register offsets within the expanded register bank
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_SHORT_CTL = 4'h0;
  localparam logic [3:0] OFS_SHARED_CTL = 4'h1;
  localparam logic [3:0] OFS_LONG_CTL = 4'h2;
  localparam logic [3:0] OFS_SYNC_CTL = 4'h3;
  localparam logic [3:0] OFS_SHORT_RELOAD = 4'h4;
  localparam logic [3:0] OFS_LONG_RELOAD_LO = 4'h5;
  localparam logic [3:0] OFS_LONG_RELOAD_HI = 4'h6;
  localparam logic [3:0] OFS_CAPTURE_LO = 4'h7;
  localparam logic [3:0] OFS_CAPTURE_HI = 4'h8;

  // ------------------------------------------------------------
  // Field positions of the short and long timer control registers
  // ------------------------------------------------------------
  localparam int B_ENABLE = 7;
  localparam int B_SINGLE = 6;
  localparam int B_TIMEOUT = 5;
  localparam int B_CLKSEL = 4;
  localparam int B_CAP_MASK = 2;
  localparam int B_CNT_MASK = 1;
  localparam int B_PIN_SEL = 0;

  // ------------------------------------------------------------
  // Field positions of the shared and sync control registers
  // ------------------------------------------------------------
  localparam int B_DEMOD_MODE = 7;
  localparam int B_THIRD_PIN = 6;
  localparam int B_LOGIC_HI = 5;
  localparam int B_LOGIC_LO = 4;
  localparam int B_PING_PONG = 3;
  localparam int B_EDGE_HI = 1;
  localparam int B_EDGE_LO = 0;
  localparam int B_SYNC_LONG_EN = 7;
  localparam int B_SYNC_SHORT_EN = 6;
  localparam int B_SYNC_MODE = 5;

  // ------------------------------------------------------------
  // Reset values and encodings
  // ------------------------------------------------------------
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [1:0] LOGIC_AND = 2'h0;
  localparam logic [1:0] LOGIC_OR = 2'h1;
  localparam logic [1:0] LOGIC_XOR = 2'h2;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;

  // ------------------------------------------------------------
  // Count clock prescaler: fast rate SYS_CLK/2, slow rate SYS_CLK/16
  // ------------------------------------------------------------
  localparam int PRESC_W = 4;
  localparam logic [3:0] PRESC_FAST_MASK = 4'h1;
  localparam logic [3:0] PRESC_SLOW_MASK = 4'hf;

endpackage

// [design/dct_counter.sv]
`timescale 1ns/1ps
module dct_counter #(
  parameter int WIDTH = 8
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic load,
  input wire logic run,
  input wire logic tick,
  input wire logic [WIDTH-1:0] reload_val,
  output logic [WIDTH-1:0] count,
  output logic tc
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } dct_cnt_state_t;

  dct_cnt_state_t s_r;
  dct_cnt_state_t s_nxt;

  // ------------------------------------------------------------
  // Down counter, terminal count at zero
  // ------------------------------------------------------------
  assign tc = run & tick & (s_r.cnt == '0) & ~load;
  assign count = s_r.cnt;

  always_comb
  begin
    s_nxt = s_r;
    if (load)
    begin
      s_nxt.cnt = reload_val;
    end
    else if (run & tick)
    begin
      if (s_r.cnt == '0)
      begin
        s_nxt.cnt = reload_val;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule // dct_counter

// [design/dct_timer_ctrl.sv]
// How it works
// - Writing enable one starts the short counter
// - Reload at terminal count, or halt when single
// - Short timeout sets at terminal count, write-one clears
// - First count tick may be short, any phase
// - Demod captures every edge, or first edge only
// - Long timeout sets at terminal count, write-one clears
// - Capture mask raises request on each capture
// - Long mask raises request on long timeout
// - One clock-select bit per timer picks rate
// - Sync register shows and sets both enables
// - Sync mode bit runs counters together, default off
// - Ping-pong hardware alternates both enable bits
// - Ping-pong sets each timeout on terminal count
// - Short pin select routes short output to pin
// - Long pin select routes long output to pin
// - Third pin drives selected logic of outputs
// - Shared bits differ between transmit and demod
// - Timers give two interrupt request sources
`timescale 1ns/1ps
module dct_timer_ctrl #(
  parameter int SHORT_W = 8,
  parameter int LONG_W = 16
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic DEMOD_IN,
  input wire logic [2:0] PORT_DATA,
  output logic FIRST_OUTPUT_PIN,
  output logic SECOND_OUTPUT_PIN,
  output logic THIRD_OUTPUT_PIN,
  output logic SHORT_IRQ,
  output logic LONG_IRQ
);

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  generate
    if (SHORT_W < 2 || SHORT_W > 8 || LONG_W < 9 || LONG_W > 16)
    begin : g_bad_width
      $error("dct_timer_ctrl: SHORT_W must be 2..8 and LONG_W 9..16");
    end
  endgenerate

  typedef struct packed {
    logic [7:0] sctl;
    logic [7:0] lctl;
    logic [7:0] shctl;
    logic sync_mode;
    logic [7:0] s_reload;
    logic [15:0] l_reload;
    logic [15:0] capture;
    logic [dct_pkg::PRESC_W-1:0] presc;
    logic demod_m;
    logic demod_s;
    logic demod_d;
    logic first_done;
    logic short_out;
    logic long_out;
    logic pin1;
    logic pin2;
    logic pin3;
    logic s_irq;
    logic l_irq;
    logic [7:0] rdata;
  } dct_state_t;

  dct_state_t s_r;
  dct_state_t s_nxt;

  logic s_load;
  logic l_load;
  logic s_tick;
  logic l_tick;
  logic s_tc;
  logic l_tc;
  logic [SHORT_W-1:0] s_count;
  logic [LONG_W-1:0] l_count;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic tick_of(input logic [dct_pkg::PRESC_W-1:0] presc,
                                   input logic slow);
    logic [dct_pkg::PRESC_W-1:0] m;
    m = slow ? dct_pkg::PRESC_SLOW_MASK : dct_pkg::PRESC_FAST_MASK;
    tick_of = (presc & m) == m;
  endfunction

  function automatic logic combine(input logic [1:0] sel, input logic a,
                                   input logic b);
    logic r;
    r = ~(a | b);
    case (sel)
      dct_pkg::LOGIC_AND: r = a & b;
      dct_pkg::LOGIC_OR: r = a | b;
      dct_pkg::LOGIC_XOR: r = a ^ b;
      default: r = ~(a | b);
    endcase
    combine = r;
  endfunction

  assign s_tick = tick_of(s_r.presc, s_r.sctl[dct_pkg::B_CLKSEL]);
  assign l_tick = tick_of(s_r.presc, s_r.lctl[dct_pkg::B_CLKSEL]);

  // ------------------------------------------------------------
  // Counters
  // ------------------------------------------------------------
  dct_counter #(
    .WIDTH(SHORT_W)
  ) u_short (
    .SYS_CLK(SYS_CLK),
    .SRST(SRST),
    .load(s_load),
    .run(s_r.sctl[dct_pkg::B_ENABLE]),
    .tick(s_tick),
    .reload_val(s_r.s_reload[SHORT_W-1:0]),
    .count(s_count),
    .tc(s_tc)
  );

  dct_counter #(
    .WIDTH(LONG_W)
  ) u_long (
    .SYS_CLK(SYS_CLK),
    .SRST(SRST),
    .load(l_load),
    .run(s_r.lctl[dct_pkg::B_ENABLE]),
    .tick(l_tick),
    .reload_val(s_r.l_reload[LONG_W-1:0]),
    .count(l_count),
    .tc(l_tc)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic demod;
    logic pp;
    logic edge_seen;
    logic accept;
    logic wr_s;
    logic wr_l;
    demod = s_r.shctl[dct_pkg::B_DEMOD_MODE];
    pp = s_r.shctl[dct_pkg::B_PING_PONG] & ~demod;
    edge_seen = 1'b0;
    accept = 1'b0;
    wr_s = REG_WR & (REG_ADDR == dct_pkg::OFS_SHORT_CTL);
    wr_l = REG_WR & (REG_ADDR == dct_pkg::OFS_LONG_CTL);
    s_nxt = s_r;
    s_nxt.demod_m = DEMOD_IN;
    s_nxt.demod_s = s_r.demod_m;
    s_nxt.demod_d = s_r.demod_s;
    // Free-running prescaler gives the first tick an arbitrary phase
    s_nxt.presc = s_r.presc + dct_pkg::PRESC_W'(1);

    // Register writes
    if (wr_s)
    begin
      s_nxt.sctl = REG_WDATA;
      s_nxt.sctl[dct_pkg::B_TIMEOUT] = s_r.sctl[dct_pkg::B_TIMEOUT]
        & ~REG_WDATA[dct_pkg::B_TIMEOUT];
    end
    if (wr_l)
    begin
      s_nxt.lctl = REG_WDATA;
      s_nxt.lctl[dct_pkg::B_TIMEOUT] = s_r.lctl[dct_pkg::B_TIMEOUT]
        & ~REG_WDATA[dct_pkg::B_TIMEOUT];
    end
    if (REG_WR)
    begin
      case (REG_ADDR)
        dct_pkg::OFS_SHARED_CTL: s_nxt.shctl = REG_WDATA;
        dct_pkg::OFS_SHORT_RELOAD: s_nxt.s_reload = REG_WDATA;
        dct_pkg::OFS_LONG_RELOAD_LO: s_nxt.l_reload[7:0] = REG_WDATA;
        dct_pkg::OFS_LONG_RELOAD_HI: s_nxt.l_reload[15:8] = REG_WDATA;
        dct_pkg::OFS_SYNC_CTL:
        begin
          s_nxt.sync_mode = REG_WDATA[dct_pkg::B_SYNC_MODE];
          if (REG_WDATA[dct_pkg::B_SYNC_MODE])
          begin
            // Both counters start together from a fresh prescaler phase
            s_nxt.sctl[dct_pkg::B_ENABLE] = REG_WDATA[dct_pkg::B_SYNC_LONG_EN]
              | REG_WDATA[dct_pkg::B_SYNC_SHORT_EN];
            s_nxt.lctl[dct_pkg::B_ENABLE] = s_nxt.sctl[dct_pkg::B_ENABLE];
            s_nxt.presc = '0;
          end
          else
          begin
            s_nxt.sctl[dct_pkg::B_ENABLE] = REG_WDATA[dct_pkg::B_SYNC_SHORT_EN];
            s_nxt.lctl[dct_pkg::B_ENABLE] = REG_WDATA[dct_pkg::B_SYNC_LONG_EN];
          end
        end
        default:
        begin
        end
      endcase
    end

    // Terminal count of the short counter
    if (s_tc)
    begin
      s_nxt.sctl[dct_pkg::B_TIMEOUT] = 1'b1;
      s_nxt.short_out = ~s_r.short_out;
      if (pp)
      begin
        s_nxt.sctl[dct_pkg::B_ENABLE] = 1'b0;
        s_nxt.lctl[dct_pkg::B_ENABLE] = 1'b1;
      end
      else if (s_r.sctl[dct_pkg::B_SINGLE])
      begin
        s_nxt.sctl[dct_pkg::B_ENABLE] = 1'b0;
      end
    end

    // Terminal count of the long counter
    if (l_tc)
    begin
      s_nxt.lctl[dct_pkg::B_TIMEOUT] = 1'b1;
      s_nxt.long_out = ~s_r.long_out;
      if (pp)
      begin
        s_nxt.lctl[dct_pkg::B_ENABLE] = 1'b0;
        s_nxt.sctl[dct_pkg::B_ENABLE] = 1'b1;
      end
      else if (s_r.lctl[dct_pkg::B_SINGLE] & ~demod)
      begin
        s_nxt.lctl[dct_pkg::B_ENABLE] = 1'b0;
      end
    end

    // Demodulation edge capture
    case (s_r.shctl[dct_pkg::B_EDGE_HI:dct_pkg::B_EDGE_LO])
      dct_pkg::EDGE_FALL: edge_seen = s_r.demod_d & ~s_r.demod_s;
      dct_pkg::EDGE_RISE: edge_seen = ~s_r.demod_d & s_r.demod_s;
      default: edge_seen = s_r.demod_d ^ s_r.demod_s;
    endcase
    accept = demod & s_r.lctl[dct_pkg::B_ENABLE] & edge_seen
      & ~(s_r.lctl[dct_pkg::B_SINGLE] & s_r.first_done);
    if (accept)
    begin
      s_nxt.capture = 16'(l_count);
      s_nxt.first_done = 1'b1;
    end

    // Start loads the initial value; a new run re-arms the first edge
    s_load = s_nxt.sctl[dct_pkg::B_ENABLE] & ~s_r.sctl[dct_pkg::B_ENABLE];
    l_load = (s_nxt.lctl[dct_pkg::B_ENABLE] & ~s_r.lctl[dct_pkg::B_ENABLE])
      | accept;
    if (s_nxt.lctl[dct_pkg::B_ENABLE] & ~s_r.lctl[dct_pkg::B_ENABLE])
    begin
      s_nxt.first_done = 1'b0;
    end

    // Interrupt requests, one per timer, in the flag-setting cycle
    s_nxt.s_irq = s_tc & s_r.sctl[dct_pkg::B_CNT_MASK];
    s_nxt.l_irq = (l_tc & s_r.lctl[dct_pkg::B_CNT_MASK])
      | (accept & s_r.lctl[dct_pkg::B_CAP_MASK]);

    // Pin routing
    s_nxt.pin1 = s_r.sctl[dct_pkg::B_PIN_SEL] ? s_r.short_out : PORT_DATA[0];
    s_nxt.pin2 = s_r.lctl[dct_pkg::B_PIN_SEL] ? s_r.long_out : PORT_DATA[1];
    s_nxt.pin3 = s_r.shctl[dct_pkg::B_THIRD_PIN]
      ? combine(s_r.shctl[dct_pkg::B_LOGIC_HI:dct_pkg::B_LOGIC_LO],
                s_r.short_out, s_r.long_out)
      : PORT_DATA[2];

    // Read data, one cycle after the address
    case (REG_ADDR)
      dct_pkg::OFS_SHORT_CTL: s_nxt.rdata = s_r.sctl;
      dct_pkg::OFS_SHARED_CTL: s_nxt.rdata = s_r.shctl;
      dct_pkg::OFS_LONG_CTL: s_nxt.rdata = s_r.lctl;
      dct_pkg::OFS_SYNC_CTL: s_nxt.rdata = {s_r.lctl[dct_pkg::B_ENABLE],
        s_r.sctl[dct_pkg::B_ENABLE], s_r.sync_mode, 5'h00};
      dct_pkg::OFS_SHORT_RELOAD: s_nxt.rdata = s_r.s_reload;
      dct_pkg::OFS_LONG_RELOAD_LO: s_nxt.rdata = s_r.l_reload[7:0];
      dct_pkg::OFS_LONG_RELOAD_HI: s_nxt.rdata = s_r.l_reload[15:8];
      dct_pkg::OFS_CAPTURE_LO: s_nxt.rdata = s_r.capture[7:0];
      dct_pkg::OFS_CAPTURE_HI: s_nxt.rdata = s_r.capture[15:8];
      default: s_nxt.rdata = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      s_r <= '0;
      s_r.sctl <= dct_pkg::RST_CTL;
      s_r.lctl <= dct_pkg::RST_CTL;
      s_r.shctl <= dct_pkg::RST_CTL;
      s_r.s_reload <= dct_pkg::RST_RELOAD;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign REG_RDATA = s_r.rdata;
  assign FIRST_OUTPUT_PIN = s_r.pin1;
  assign SECOND_OUTPUT_PIN = s_r.pin2;
  assign THIRD_OUTPUT_PIN = s_r.pin3;
  assign SHORT_IRQ = s_r.s_irq;
  assign LONG_IRQ = s_r.l_irq;

endmodule // dct_timer_ctrl

// [tb/dct_timer_ctrl_assertions.sv]
`timescale 1ns/1ps
module dct_timer_ctrl_checker (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic DEMOD_IN,
  input wire logic [2:0] PORT_DATA,
  input wire logic FIRST_OUTPUT_PIN,
  input wire logic SECOND_OUTPUT_PIN,
  input wire logic THIRD_OUTPUT_PIN,
  input wire logic SHORT_IRQ,
  input wire logic LONG_IRQ
);
  // ----------------------------------------
  // Shadow of the written select and mask bits
  // ----------------------------------------
  typedef struct packed {
    logic s_sel;
    logic l_sel;
    logic t_en;
    logic s_msk;
    logic [1:0] l_msk;
  } dct_shadow_t;
  dct_shadow_t sh_r;
  dct_shadow_t sh_nxt;
  always_comb
  begin
    sh_nxt = sh_r;
    if (REG_WR && REG_ADDR == dct_pkg::OFS_SHORT_CTL)
    begin
      sh_nxt.s_sel = REG_WDATA[0];
      sh_nxt.s_msk = REG_WDATA[1];
    end
    if (REG_WR && REG_ADDR == dct_pkg::OFS_LONG_CTL)
    begin
      sh_nxt.l_sel = REG_WDATA[0];
      sh_nxt.l_msk = REG_WDATA[2:1];
    end
    if (REG_WR && REG_ADDR == dct_pkg::OFS_SHARED_CTL)
      sh_nxt.t_en = REG_WDATA[6];
    if (SRST)
      sh_nxt = '0;
  end
  always_ff @(posedge SYS_CLK)
    sh_r <= sh_nxt;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  sequence s_short_event;
    SHORT_IRQ && !REG_WR && REG_ADDR == 4'h0 ##1 !REG_WR && REG_ADDR == 4'h0;
  endsequence
  sequence s_flag_seen;
    ##[0:1] REG_RDATA[5];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    SRST |=> REG_RDATA == 8'h00 && !SHORT_IRQ && !LONG_IRQ) else $error("output after reset");
  a_unmapped_zero: assert property (REG_ADDR > 4'h8 |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_sync_low: assert property (REG_ADDR == 4'h3 |=> REG_RDATA[4:0] == 5'h00)
    else $error("sync low bits set");
  a_pin1_port: assert property (!sh_r.s_sel |=> FIRST_OUTPUT_PIN == $past(PORT_DATA[0]))
    else $error("pin1 port data");
  a_pin2_port: assert property (!sh_r.l_sel |=> SECOND_OUTPUT_PIN == $past(PORT_DATA[1]))
    else $error("pin2 port data");
  a_pin3_port: assert property (!sh_r.t_en |=> THIRD_OUTPUT_PIN == $past(PORT_DATA[2]))
    else $error("pin3 port data");
  a_short_masked: assert property (!sh_r.s_msk [*2] |=> !SHORT_IRQ)
    else $error("short request while masked");
  a_long_masked: assert property ((sh_r.l_msk == 2'h0) [*2] |=> !LONG_IRQ)
    else $error("long request while masked");
  a_short_pulse: assert property (SHORT_IRQ |=> !SHORT_IRQ)
    else $error("short request too long");
  a_short_flag: assert property (s_short_event |-> s_flag_seen)
    else $error("request without flag");
endmodule // dct_timer_ctrl_checker

bind dct_timer_ctrl dct_timer_ctrl_checker u_dct_timer_ctrl_checker (.SYS_CLK(SYS_CLK),
  .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .DEMOD_IN(DEMOD_IN), .PORT_DATA(PORT_DATA),
  .FIRST_OUTPUT_PIN(FIRST_OUTPUT_PIN), .SECOND_OUTPUT_PIN(SECOND_OUTPUT_PIN),
  .THIRD_OUTPUT_PIN(THIRD_OUTPUT_PIN), .SHORT_IRQ(SHORT_IRQ), .LONG_IRQ(LONG_IRQ));

// [tb/test_dct_timer_ctrl.sv]
`timescale 1ns/1ps
module test_dct_timer_ctrl;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic demod_in = 1'b0;
  logic [2:0] port_data = 3'h0;
  logic pin1, pin2, pin3, short_irq, long_irq;
  logic [7:0] rv;
  int n;
  int miscompares = 0;
  int checks = 0;
  always #10 sys_clk = ~sys_clk;
  dct_timer_ctrl u_dct_timer_ctrl (.SYS_CLK(sys_clk), .SRST(srst), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .DEMOD_IN(demod_in),
    .PORT_DATA(port_data), .FIRST_OUTPUT_PIN(pin1), .SECOND_OUTPUT_PIN(pin2),
    .THIRD_OUTPUT_PIN(pin3), .SHORT_IRQ(short_irq), .LONG_IRQ(long_irq));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    #1;
    chk(reg_rdata & m, e);
  endtask
  task automatic wait_irq(input bit lng, input int lim);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    while ((lng ? long_irq : short_irq) !== 1'b1 && n < lim);
  endtask
  // Third interval is free of any rate or enable change
  task automatic period(input bit lng, input logic [7:0] e);
    repeat (3) wait_irq(lng, 100);
    chk(n[7:0], e);
  endtask
  task automatic pins(input logic [2:0] e);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({5'h0, pin3, pin2, pin1}, {5'h0, e});
  endtask
  task automatic edge_irq(input logic e);
    @(posedge sys_clk);
    demod_in <= 1'b1;
    wait_irq(1'b1, 12);
    chk({7'h0, long_irq}, {7'h0, e});
    @(posedge sys_clk);
    demod_in <= 1'b0;
    repeat (12) @(posedge sys_clk);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    for (int a = 0; a < 16; a++)
      rc(a[3:0], 8'hff, 8'h00);
    @(posedge sys_clk);
    port_data <= 3'h5;
    pins(3'h5);
    wr(4'h0, 8'h01);
    wr(4'h2, 8'h01);
    pins(3'h4);
    for (int c = 0; c < 4; c++)
    begin
      wr(4'h1, {2'h1, c[1:0], 4'h0});
      pins({c == 3, 2'h0});
    end
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h20);
    wr(4'h2, 8'h20);
    @(posedge sys_clk);
    port_data <= 3'h0;
    wr(4'h4, 8'h03);
    wr(4'h0, 8'hc3);
    wait_irq(1'b0, 40);
    rc(4'h0, 8'hff, 8'h63);
    pins(3'h1);
    rc(4'h3, 8'hff, 8'h00);
    wr(4'h0, 8'h43);
    rc(4'h0, 8'hff, 8'h63);
    wr(4'h0, 8'h63);
    rc(4'h0, 8'hff, 8'h43);
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h82);
    period(1'b0, 8'h04);
    wr(4'h0, 8'h92);
    period(1'b0, 8'h20);
    wr(4'h0, 8'h20);
    rc(4'h0, 8'hff, 8'h00);
    wr(4'h5, 8'h02);
    wr(4'h6, 8'h00);
    wr(4'h2, 8'h82);
    period(1'b1, 8'h06);
    rc(4'h2, 8'hff, 8'ha2);
    wr(4'h2, 8'h20);
    rc(4'h2, 8'hff, 8'h00);
    wr(4'h3, 8'hc0);
    rc(4'h3, 8'he0, 8'hc0);
    rc(4'h0, 8'h80, 8'h80);
    wr(4'h3, 8'h00);
    rc(4'h3, 8'he0, 8'h00);
    rc(4'h2, 8'h80, 8'h00);
    wr(4'h3, 8'h60);
    rc(4'h3, 8'he0, 8'he0);
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h20);
    wr(4'h2, 8'h20);
    wr(4'h1, 8'h08);
    wr(4'h2, 8'h42);
    wr(4'h0, 8'hc2);
    wait_irq(1'b0, 40);
    rc(4'h3, 8'hc0, 8'h80);
    wait_irq(1'b1, 40);
    rc(4'h3, 8'hc0, 8'h40);
    rc(4'h0, 8'h20, 8'h20);
    rc(4'h2, 8'h20, 8'h20);
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h20);
    wr(4'h2, 8'h20);
    wr(4'h5, 8'hff);
    wr(4'h6, 8'hff);
    wr(4'h1, 8'h81);
    wr(4'h2, 8'h84);
    edge_irq(1'b1);
    edge_irq(1'b1);
    rc(4'h8, 8'hff, 8'hff);
    wr(4'h2, 8'h00);
    wr(4'h2, 8'hc4);
    edge_irq(1'b1);
    edge_irq(1'b0);
    conclude();
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
endmodule // test_dct_timer_ctrl
